// >>> rtl/rcr_pkg.sv
// Purpose: Types shared by the radio config register block
// Assumes: Constants live in rcr_regs.svh
// Notes:   Rate codes follow the {low, high} bit pair
package rcr_pkg;

    typedef enum logic [1:0] {
        RCR_RATE_1M   = 2'b00,
        RCR_RATE_2M   = 2'b01,
        RCR_RATE_250K = 2'b10,
        RCR_RATE_2M_B = 2'b11
    } rcr_rate_e;

    typedef enum logic [1:0] {
        RCR_SP_IDLE = 2'b00,
        RCR_SP_CMD  = 2'b01,
        RCR_SP_DATA = 2'b10
    } rcr_spi_st_e;

    typedef struct packed {
        logic [2:0] addr_bytes;
        logic [4:0] addr_byte_mask;
        logic [6:0] channel;
        rcr_rate_e  rate;
        logic       force_lock;
        logic [1:0] tx_power;
        logic       rx_gain_high;
    } rcr_cfg_s;

endpackage

// >>> rtl/rcr_radio_config_regs.sv
// Purpose: Config and status registers 03..07 with serial host access
// Assumes: Host is serial master in mode 0; events arrive on clk
// Notes:   Bank 1 registers are held elsewhere
// Contract
// - Width code 01/10/11 gives 3/4/5 bytes
// - Short widths use low address bytes
// - Retry wait is 250 us times code+1
// - Retry count caps retransmissions, zero disables
// - Seven-bit channel, bit 7 reserved
// - Rate bit pair selects air rate
// - Test bit forces synthesizer lock
// - Two-bit transmit power, resets to 11
// - Status shifts out during command byte
// - Status bit 7 shows active bank
// - Toggle command plus 0x53 flips bank
// - Receive-ready flag set on new packet
// - Writing one clears a status flag
// - Sent flag waits for acknowledgement when enabled
`timescale 1ns/1ps
`include "rcr_regs.svh"
`default_nettype none
module rcr_radio_config_regs #(
    parameter int RETRY_STEP_CYCLES = `RCR_RETRY_STEP_US * `RCR_CLK_MHZ
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       spi_sck,
    input  wire logic       spi_csn_n,
    input  wire logic       spi_mosi,
    output logic            spi_miso,
    output logic            spi_miso_oe_n,
    input  wire logic       rx_packet_evt,
    input  wire logic       tx_done_evt,
    input  wire logic       ack_rcvd_evt,
    input  wire logic       ack_fail_evt,
    input  wire logic       auto_ack,
    output rcr_pkg::rcr_cfg_s cfg_q,
    output logic            retx_start_q,
    output logic            bank_indicator_q
);
    import rcr_pkg::*;

    logic [1:0]  width_code_q;
    logic [3:0]  rdelay_q;
    logic [3:0]  rcount_q;
    logic [6:0]  chan_q;
    logic        rate_low_q;
    logic        force_lock_q;
    logic        rate_high_q;
    logic [1:0]  tx_power_q;
    logic        rx_gain_q;
    logic        rx_ready_q;
    logic        tx_sent_q;
    logic        retry_lim_q;

    logic        rdy_s1_q;
    logic        rdy_s2_q;
    logic        rdy_s3_q;
    logic        csn_s1_q;
    logic        csn_s2_q;
    logic        csn_s3_q;
    logic        sck_s1_q;
    logic        sck_s2_q;
    logic        sck_s3_q;
    logic        rdy_rise;
    logic        csn_fall;
    logic        sck_fall;
    logic        rdy_raw;
    logic [7:0]  rx_byte;

    rcr_spi_st_e st_q;
    logic [7:0]  cmd_q;
    logic        first_q;
    logic [7:0]  tx_next_q;
    logic [7:0]  tx_sh_q;
    logic [2:0]  tx_bit_q;

    logic        wr_status;
    logic [7:0]  wr_byte;

    logic [3:0]  attempts_q;
    logic        waiting_q;
    logic [31:0] step_cnt_q;
    logic [4:0]  steps_left_q;

    function automatic logic [7:0] status_byte(input logic bank, input logic rx,
                                               input logic tx, input logic mr);
        status_byte = 8'h00;
        status_byte[`RCR_ST_BANK]   = bank;
        status_byte[`RCR_ST_RX_READY]  = rx;
        status_byte[`RCR_ST_TX_SENT]   = tx;
        status_byte[`RCR_ST_RETRY_LIM] = mr;
    endfunction

    function automatic logic [2:0] width_bytes(input logic [1:0] code);
        if (code == `RCR_WIDTH_3B) begin
            width_bytes = 3'd3;
        end else if (code == `RCR_WIDTH_4B) begin
            width_bytes = 3'd4;
        end else begin
            width_bytes = 3'd5;
        end
    endfunction

    rcr_spi_rx u_rx (
        .spi_sck    (spi_sck),
        .spi_csn_n  (spi_csn_n),
        .spi_mosi   (spi_mosi),
        .byte_rdy_q (rdy_raw),
        .byte_q     (rx_byte)
    );

    // Pins and the byte-ready level pass two flops first
    always_ff @(posedge clk) begin
        if (reset) begin
            {rdy_s1_q, rdy_s2_q, rdy_s3_q} <= 3'h0;
            {csn_s1_q, csn_s2_q, csn_s3_q} <= 3'h7;
            {sck_s1_q, sck_s2_q, sck_s3_q} <= 3'h0;
        end else begin
            {rdy_s1_q, rdy_s2_q, rdy_s3_q} <= {rdy_raw, rdy_s1_q, rdy_s2_q};
            {csn_s1_q, csn_s2_q, csn_s3_q} <= {spi_csn_n, csn_s1_q, csn_s2_q};
            {sck_s1_q, sck_s2_q, sck_s3_q} <= {spi_sck, sck_s1_q, sck_s2_q};
        end
    end

    assign rdy_rise = rdy_s2_q & ~rdy_s3_q;
    assign csn_fall = ~csn_s2_q & csn_s3_q;
    assign sck_fall = ~sck_s2_q & sck_s3_q & ~csn_s2_q;

    // Command decode; bank 1 registers are not held here
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q      <= RCR_SP_IDLE;
            cmd_q     <= 8'hff;
            first_q   <= 1'b0;
            tx_next_q <= 8'h00;
            bank_indicator_q <= 1'b0;
        end else begin
            case (st_q)
                RCR_SP_IDLE: begin
                    if (csn_fall) begin
                        st_q <= RCR_SP_CMD;
                    end
                end
                RCR_SP_CMD: begin
                    if (csn_s2_q) begin
                        st_q <= RCR_SP_IDLE;
                    end else if (rdy_rise) begin
                        cmd_q   <= rx_byte;
                        first_q <= 1'b1;
                        st_q    <= RCR_SP_DATA;
                        if (rx_byte[7:5] == `RCR_OP_READ && !bank_indicator_q) begin
                            tx_next_q <= rd_data(rx_byte[4:0]);
                        end else begin
                            tx_next_q <= 8'h00;
                        end
                    end
                end
                RCR_SP_DATA: begin
                    if (csn_s2_q) begin
                        st_q <= RCR_SP_IDLE;
                    end else if (rdy_rise) begin
                        first_q   <= 1'b0;
                        tx_next_q <= 8'h00;
                        if (first_q && cmd_q == `RCR_CMD_BANK_TOGGLE
                            && rx_byte == `RCR_BANK_KEY) begin
                            bank_indicator_q <= ~bank_indicator_q;
                        end
                    end
                end
                default: begin
                    st_q <= RCR_SP_IDLE;
                end
            endcase
        end
    end

    assign wr_byte   = rx_byte;
    assign wr_status = (st_q == RCR_SP_DATA) && !csn_s2_q && rdy_rise && first_q
                       && cmd_q[7:5] == `RCR_OP_WRITE && !bank_indicator_q;

    function automatic logic [7:0] rd_data(input logic [4:0] a);
        rd_data = 8'h00;
        if (a == `RCR_ADDR_WIDTH) begin
            rd_data = {6'h00, width_code_q};
        end else if (a == `RCR_ADDR_RETR) begin
            rd_data = {rdelay_q, rcount_q};
        end else if (a == `RCR_ADDR_CHAN) begin
            rd_data = {1'b0, chan_q};
        end else if (a == `RCR_ADDR_RADIO) begin
            rd_data = {2'b00, rate_low_q, force_lock_q, rate_high_q, tx_power_q, rx_gain_q};
        end else if (a == `RCR_ADDR_STATUS) begin
            rd_data = status_byte(bank_indicator_q, rx_ready_q, tx_sent_q, retry_lim_q);
        end
    endfunction

    // Reserved bits are dropped; host must write them as zero
    always_ff @(posedge clk) begin
        if (reset) begin
            width_code_q <= `RCR_RST_WIDTH;
            rdelay_q     <= `RCR_RST_RDELAY;
            rcount_q     <= `RCR_RST_RCOUNT;
            chan_q       <= `RCR_RST_CHAN;
            rate_low_q   <= `RCR_RST_RATE_LOW;
            force_lock_q <= `RCR_RST_FORCE_LOCK;
            rate_high_q  <= `RCR_RST_RATE_HIGH;
            tx_power_q   <= `RCR_RST_TX_POWER;
            rx_gain_q    <= `RCR_RST_RX_GAIN;
        end else if (wr_status) begin
            if (cmd_q[4:0] == `RCR_ADDR_WIDTH) begin
                width_code_q <= wr_byte[1:0];
            end else if (cmd_q[4:0] == `RCR_ADDR_RETR) begin
                rdelay_q <= wr_byte[7:4];
                rcount_q <= wr_byte[3:0];
            end else if (cmd_q[4:0] == `RCR_ADDR_CHAN) begin
                chan_q <= wr_byte[6:0];
            end else if (cmd_q[4:0] == `RCR_ADDR_RADIO) begin
                rate_low_q   <= wr_byte[`RCR_RADIO_RATE_LOW];
                force_lock_q <= wr_byte[`RCR_RADIO_LOCK];
                rate_high_q  <= wr_byte[`RCR_RADIO_RATE_HIGH];
                tx_power_q   <= wr_byte[`RCR_RADIO_PWR_HI:`RCR_RADIO_PWR_LO];
                rx_gain_q    <= wr_byte[`RCR_RADIO_GAIN];
            end
        end
    end

    // Write one to clear, set wins
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_ready_q  <= 1'b0;
            tx_sent_q   <= 1'b0;
            retry_lim_q <= 1'b0;
        end else begin
            rx_ready_q  <= rx_packet_evt | (rx_ready_q & ~(wr_status
                        && cmd_q[4:0] == `RCR_ADDR_STATUS && wr_byte[`RCR_ST_RX_READY]));
            tx_sent_q   <= (auto_ack ? ack_rcvd_evt : tx_done_evt) | (tx_sent_q & ~(wr_status
                        && cmd_q[4:0] == `RCR_ADDR_STATUS && wr_byte[`RCR_ST_TX_SENT]));
            retry_lim_q <= (ack_fail_evt && !waiting_q && attempts_q >= rcount_q)
                        | (retry_lim_q & ~(wr_status
                        && cmd_q[4:0] == `RCR_ADDR_STATUS && wr_byte[`RCR_ST_RETRY_LIM]));
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_sh_q       <= 8'h00;
            tx_bit_q      <= 3'h0;
            spi_miso      <= 1'b0;
            spi_miso_oe_n <= 1'b1;
        end else begin
            spi_miso_oe_n <= csn_s2_q;
            if (csn_fall) begin
                tx_sh_q  <= status_byte(bank_indicator_q, rx_ready_q, tx_sent_q, retry_lim_q);
                spi_miso <= bank_indicator_q;
                tx_bit_q <= 3'h0;
            end else if (sck_fall) begin
                tx_bit_q <= tx_bit_q + 3'h1;
                if (tx_bit_q == 3'h7) begin
                    tx_sh_q  <= tx_next_q;
                    spi_miso <= tx_next_q[7];
                end else begin
                    tx_sh_q  <= {tx_sh_q[6:0], 1'b0};
                    spi_miso <= tx_sh_q[6];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            attempts_q   <= 4'h0;
            waiting_q    <= 1'b0;
            step_cnt_q   <= 32'h0;
            steps_left_q <= 5'h0;
            retx_start_q <= 1'b0;
        end else begin
            retx_start_q <= 1'b0;
            if (ack_rcvd_evt || (tx_done_evt && !auto_ack)) begin
                attempts_q <= 4'h0;
                waiting_q  <= 1'b0;
            end else if (ack_fail_evt && !waiting_q) begin
                if (attempts_q < rcount_q) begin
                    // Wait of code plus one steps
                    waiting_q    <= 1'b1;
                    step_cnt_q   <= 32'(RETRY_STEP_CYCLES - 1);
                    steps_left_q <= {1'b0, rdelay_q};
                end else begin
                    attempts_q <= 4'h0;
                end
            end else if (waiting_q) begin
                if (step_cnt_q != 32'h0) begin
                    step_cnt_q <= step_cnt_q - 32'h1;
                end else if (steps_left_q != 5'h0) begin
                    steps_left_q <= steps_left_q - 5'h1;
                    step_cnt_q   <= 32'(RETRY_STEP_CYCLES - 1);
                end else begin
                    waiting_q    <= 1'b0;
                    retx_start_q <= 1'b1;
                    attempts_q   <= attempts_q + 4'h1;
                end
            end
        end
    end

    // Config fanout registered so outputs come from flops
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_q <= '0;
        end else begin
            cfg_q.addr_bytes     <= width_bytes(width_code_q);
            cfg_q.addr_byte_mask <= (width_bytes(width_code_q) == 3'd3) ? 5'h07 :
                                    (width_bytes(width_code_q) == 3'd4) ? 5'h0f : 5'h1f;
            cfg_q.channel        <= chan_q;
            cfg_q.rate           <= rcr_rate_e'({rate_low_q, rate_high_q});
            cfg_q.force_lock     <= force_lock_q;
            cfg_q.tx_power       <= tx_power_q;
            cfg_q.rx_gain_high   <= rx_gain_q;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/rcr_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the radio config registers
// Assumes: Byte-wide registers reached over the four-wire serial port
// Notes:   Definitions only
`ifndef RCR_REGS_SVH
`define RCR_REGS_SVH

`define RCR_ADDR_WIDTH      5'h03
`define RCR_ADDR_RETR       5'h04
`define RCR_ADDR_CHAN       5'h05
`define RCR_ADDR_RADIO      5'h06
`define RCR_ADDR_STATUS     5'h07

`define RCR_RST_WIDTH       2'h3
`define RCR_RST_RDELAY      4'h0
`define RCR_RST_RCOUNT      4'h3
`define RCR_RST_CHAN        7'h02
`define RCR_RST_RATE_LOW    1'h0
`define RCR_RST_FORCE_LOCK  1'h0
`define RCR_RST_RATE_HIGH   1'h1
`define RCR_RST_TX_POWER    2'h3
`define RCR_RST_RX_GAIN     1'h1

`define RCR_WIDTH_3B        2'h1
`define RCR_WIDTH_4B        2'h2
`define RCR_WIDTH_5B        2'h3

`define RCR_RADIO_RATE_LOW  5
`define RCR_RADIO_LOCK      4
`define RCR_RADIO_RATE_HIGH 3
`define RCR_RADIO_PWR_HI    2
`define RCR_RADIO_PWR_LO    1
`define RCR_RADIO_GAIN      0

`define RCR_ST_BANK         7
`define RCR_ST_RX_READY     6
`define RCR_ST_TX_SENT      5
`define RCR_ST_RETRY_LIM    4

`define RCR_OP_READ         3'h0
`define RCR_OP_WRITE        3'h1
`define RCR_CMD_BANK_TOGGLE 8'h50
`define RCR_BANK_KEY        8'h53

`define RCR_CLK_MHZ         125
`define RCR_RETRY_STEP_US   250

`endif

// >>> rtl/rcr_spi_rx.sv
// Purpose: Serial byte receiver running on the host's serial clock
// Assumes: Mode 0, data taken on rising edge, MSB first
// Notes:   Chip select high clears the frame state at once
`timescale 1ns/1ps
`default_nettype none
module rcr_spi_rx (
    input  wire logic       spi_sck,
    input  wire logic       spi_csn_n,
    input  wire logic       spi_mosi,
    output logic            byte_rdy_q,
    output logic [7:0]      byte_q
);
    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;

    // Clock stops between frames, so chip select ends the frame
    always_ff @(posedge spi_sck or posedge spi_csn_n) begin
        if (spi_csn_n) begin
            bit_cnt_q  <= 3'h0;
            byte_rdy_q <= 1'b0;
        end else begin
            bit_cnt_q  <= bit_cnt_q + 3'h1;
            byte_rdy_q <= (bit_cnt_q == 3'h7);
        end
    end

    always_ff @(posedge spi_sck) begin
        shift_q <= {shift_q[5:0], spi_mosi};
    end

    // Held stable for a whole byte time while the other side reads it
    always_ff @(posedge spi_sck) begin
        if (!spi_csn_n && bit_cnt_q == 3'h7) begin
            byte_q <= {shift_q, spi_mosi};
        end
    end
endmodule
`default_nettype wire

// >>> test/rcr_radio_config_regs_monitor.sv
// Purpose: Port assertions for the radio config register block
// Assumes: Host keeps sck half periods of 40 ns or more
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module rcr_radio_config_regs_monitor #(
    parameter int RETRY_STEP_CYCLES = 20
) (
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              spi_sck,
    input wire logic              spi_csn_n,
    input wire logic              spi_miso,
    input wire logic              spi_miso_oe_n,
    input wire logic              ack_fail_evt,
    input wire rcr_pkg::rcr_cfg_s cfg_q,
    input wire logic              retx_start_q,
    input wire logic              bank_indicator_q
);
    import rcr_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Saturates so a long idle never wraps
    logic [15:0] since_q;
    always_ff @(posedge clk) begin
        if (reset || ack_fail_evt) begin
            since_q <= 16'h0;
        end else if (since_q != 16'hffff) begin
            since_q <= since_q + 16'h1;
        end
    end
    sequence frame_open;
        $fell(spi_csn_n) ##1 (!spi_csn_n && !spi_sck) [*4];
    endsequence
    sequence frame_idle;
        spi_csn_n [*4];
    endsequence
    status_lead_a: assert property (
        frame_open |-> !spi_miso_oe_n && spi_miso == bank_indicator_q)
        else $error("status bit 7 missing at frame start");
    miso_release_a: assert property (
        frame_idle |-> spi_miso_oe_n)
        else $error("miso still driven outside frame");
    cfg_reset_a: assert property ($fell(reset) |-> ##2
        cfg_q.addr_bytes == 3'd5 && cfg_q.channel == 7'h02 && cfg_q.rate == RCR_RATE_2M
        && cfg_q.tx_power == 2'h3 && !cfg_q.force_lock && cfg_q.rx_gain_high)
        else $error("configuration reset values wrong");
    mask_match_a: assert property (
        {1'b0, cfg_q.addr_byte_mask} + 6'h1 == 6'h1 << cfg_q.addr_bytes)
        else $error("address byte mask does not match width");
    width_legal_a: assert property (
        $changed(cfg_q.addr_bytes) |-> cfg_q.addr_bytes inside {[3'd3:3'd5]})
        else $error("address width outside three to five");
    retry_wait_a: assert property (
        retx_start_q |-> int'(since_q) >= RETRY_STEP_CYCLES - 1)
        else $error("retransmission started before the wait");
    retx_pulse_a: assert property (
        retx_start_q |=> !retx_start_q [*8])
        else $error("retransmission start repeated");
    bank_cause_a: assert property (
        $changed(bank_indicator_q) |-> !spi_csn_n && !$past(spi_csn_n, 2))
        else $error("bank changed outside a frame");
endmodule
bind rcr_radio_config_regs rcr_radio_config_regs_monitor #(
    .RETRY_STEP_CYCLES(RETRY_STEP_CYCLES)
) i_mon (
    .clk(clk), .reset(reset), .spi_sck(spi_sck), .spi_csn_n(spi_csn_n),
    .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n), .ack_fail_evt(ack_fail_evt),
    .cfg_q(cfg_q), .retx_start_q(retx_start_q), .bank_indicator_q(bank_indicator_q)
);
`default_nettype wire

// >>> test/rcr_radio_config_regs_tb.sv
// Purpose: Self-checking bench for the radio config registers
// Assumes: Host model drives the serial port
// Notes:   Retry step shortened to 20 cycles
`timescale 1ns/1ps
`include "rcr_regs.svh"
`default_nettype none
module rcr_radio_config_regs_tb;
    import rcr_pkg::*;
    localparam int STEP = 20;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic [3:0] evt = 4'h0;
    logic       auto_ack = 1'b0;
    wire logic  sck;
    wire logic  csn_n;
    wire logic  mosi;
    logic       miso;
    logic       miso_oe_n;
    logic       retx;
    logic       bank;
    rcr_cfg_s   cfg;
    logic [7:0] st;
    logic [7:0] rd;
    int         fails = 0;
    int         comparisons = 0;
    always #4 clk = ~clk;
    rcr_radio_config_regs #(.RETRY_STEP_CYCLES(STEP)) i_dut (
        .clk(clk), .reset(reset), .spi_sck(sck), .spi_csn_n(csn_n), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe_n(miso_oe_n), .rx_packet_evt(evt[0]),
        .tx_done_evt(evt[1]), .ack_rcvd_evt(evt[2]), .ack_fail_evt(evt[3]),
        .auto_ack(auto_ack), .cfg_q(cfg), .retx_start_q(retx), .bank_indicator_q(bank));
    // Released miso shows the inverse so a late enable is caught
    wire logic  host_miso = miso_oe_n ? ~miso : miso;
    rcr_spi_host i_host (.spi_sck(sck), .spi_csn_n(csn_n), .spi_mosi(mosi),
        .spi_miso(host_miso));
    task automatic chk(input logic [23:0] seen, want);
        comparisons++;
        if (seen !== want) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict;
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic reg_rd(input logic [4:0] a, output logic [7:0] d);
        i_host.xfer({3'h0, a}, 8'h00, st, d);
    endtask
    task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
        i_host.xfer({3'h1, a}, d, st, rd);
    endtask
    task automatic pulse(input logic [3:0] v);
        @(posedge clk);
        #1 evt = v;
        @(posedge clk);
        #1 evt = 4'h0;
    endtask
    // Counts cycles from ack failure to retransmission start, 150 means none
    task automatic fail_wait(output int n);
        pulse(4'h8);
        n = 0;
        while (retx !== 1'b1 && n < 150) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task automatic t_reset_vals;
        logic [7:0] want [5] = '{8'h03, 8'h03, 8'h02, 8'h0f, 8'h00};
        logic [7:0] d;
        chk(24'(cfg), 24'({3'd5, 5'h1f, 7'h02, RCR_RATE_2M, 4'h7}));
        for (int i = 0; i < 5; i++) begin
            reg_rd(5'(i + 3), d);
            chk(24'(d), 24'(want[i]));
            chk(24'(st), 24'h0);
        end
        reg_rd(5'h08, d);
        chk(24'(d), 24'h0);
    endtask
    task automatic t_cfg;
        logic [7:0] d;
        for (int w = 1; w < 4; w++) begin
            reg_wr(5'h03, 8'(w));
            chk(24'(cfg.addr_bytes), 24'(w + 2));
            chk(24'(cfg.addr_byte_mask), 24'((1 << (w + 2)) - 1));
        end
        for (int r = 0; r < 4; r++) begin
            reg_wr(5'h06, {2'b00, r[1], r[0], r[0], 2'(r), r[1]});
            chk(24'(cfg.rate), 24'(r));
            chk(24'(cfg.force_lock), 24'(r[0]));
            chk(24'({cfg.tx_power, cfg.rx_gain_high}), 24'({2'(r), r[1]}));
            reg_rd(5'h06, d);
            chk(24'(d), 24'({r[1], r[0], r[0], 2'(r), r[1]}));
        end
        reg_wr(5'h05, 8'h7f);
        reg_rd(5'h05, d);
        chk(24'({cfg.channel, d}), 24'h7f7f);
        reg_wr(5'h04, 8'hf5);
        reg_rd(5'h04, d);
        chk(24'(d), 24'hf5);
    endtask
    task automatic t_events;
        logic [7:0] d;
        pulse(4'h1);
        reg_rd(5'h07, d);
        chk(24'(d), 24'h40);
        pulse(4'h2);
        reg_wr(5'h07, 8'h40);
        chk(24'(st), 24'h60);
        reg_wr(5'h07, 8'h00);
        chk(24'(st), 24'h20);
        reg_wr(5'h07, 8'h20);
        @(posedge clk);
        #1 auto_ack = 1'b1;
        pulse(4'h2);
        reg_rd(5'h07, d);
        chk(24'(d), 24'h00);
        pulse(4'h4);
        reg_rd(5'h07, d);
        chk(24'(d), 24'h20);
        reg_wr(5'h07, 8'h70);
    endtask
    task automatic t_retry;
        logic [7:0] d;
        int         n;
        reg_wr(5'h04, 8'h01);
        fail_wait(n);
        chk(24'(n >= STEP && n <= STEP + 6), 24'h1);
        fail_wait(n);
        chk(24'(n), 24'd150);
        reg_rd(5'h07, d);
        chk(24'(d), 24'h10);
        reg_wr(5'h04, 8'h12);
        fail_wait(n);
        chk(24'(n >= 2 * STEP && n <= 2 * STEP + 8), 24'h1);
        pulse(4'h4);
        reg_wr(5'h04, 8'h00);
        fail_wait(n);
        chk(24'(n), 24'd150);
        reg_wr(5'h07, 8'h70);
    endtask
    task automatic t_bank;
        logic [7:0] d;
        i_host.xfer(`RCR_CMD_BANK_TOGGLE, `RCR_BANK_KEY, st, rd);
        chk(24'(bank), 24'h1);
        reg_wr(5'h05, 8'h11);
        reg_rd(5'h05, d);
        chk(24'({st, d}), 24'h8000);
        i_host.xfer(`RCR_CMD_BANK_TOGGLE, `RCR_BANK_KEY, st, rd);
        reg_rd(5'h05, d);
        chk(24'({bank, st, d}), 24'h0007f);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1 reset = 1'b0;
        repeat (6) @(posedge clk);
        t_reset_vals();
        t_cfg();
        t_events();
        t_retry();
        t_bank();
        give_verdict();
    end
    initial begin
        #400000;
        fails++;
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> test/rcr_spi_host.sv
// Purpose: Host serial master model, mode 0, MSB first
// Assumes: Own 6 ns link clock, sck half period of 7 ticks
// Notes:   Sck stands still between frames
`timescale 1ns/1ps
`default_nettype none
module rcr_spi_host (
    output logic      spi_sck,
    output logic      spi_csn_n,
    output logic      spi_mosi,
    input wire logic  spi_miso
);
    logic lclk = 1'b0;
    always #3 lclk = ~lclk;
    initial begin
        spi_sck = 1'b0;
        spi_mosi = 1'b0;
        // Late rise gives the receiver's async clear a real edge
        #1 spi_csn_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge lclk);
    endtask
    // One command byte and one data byte per frame
    task automatic xfer(input logic [7:0] cmd, dat, output logic [7:0] st, rd);
        logic [15:0] tx;
        logic [15:0] rx;
        tx = {cmd, dat};
        tick(1);
        spi_csn_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_mosi = tx[i];
            tick(7);
            spi_sck = 1'b1;
            rx[i] = spi_miso;
            tick(7);
            spi_sck = 1'b0;
        end
        tick(7);
        spi_csn_n = 1'b1;
        // Released line must not keep its last value
        spi_mosi = ~spi_mosi;
        tick(14);
        {st, rd} = rx;
    endtask
endmodule
`default_nettype wire
